/* src/dual_half_timer_capture_pwm.sv */
// Dual half timer with capture and PWM, AHB-Lite register slave and 32-bit/RTC modes
`timescale 1ns/1ps
`include "dhtcp_consts.svh"
module dual_half_timer_capture_pwm
  import dhtcp_pkg::*;
#(
  parameter int RTC_DIV = `DHTCP_RTC_CLK_HZ * `DHTCP_RTC_TICK_S
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic dbg_halt,
  input wire logic rtc_clk_in,
  input wire logic cap_a_i,
  output logic cap_a_o,
  output logic cap_a_oe,
  input wire logic cap_b_i,
  output logic cap_b_o,
  output logic cap_b_oe,
  output logic trig_a,
  output logic trig_b,
  output logic irq
);
  localparam int RDW = $clog2(RTC_DIV);

  logic [2:0] sync1_q, sync2_q;
  logic rtc_prev_q, rtc_edge;
  logic aph_wr_q, aph_wr_d;
  logic [7:0] aph_addr_q, aph_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [7:0] cfg_q, cfg_d;
  logic [11:0] ctrl_q, ctrl_d;
  logic [6:0] imask_q, imask_d, ris_q, ris_d, ev, clr;
  logic [31:0] load_a_q, load_a_d, match_a_q, match_a_d;
  logic [15:0] load_b_q, load_b_d, match_b_q, match_b_d;
  logic [7:0] presc_a_q, presc_a_d, presc_b_q, presc_b_d;
  logic [31:0] wcnt_q, wcnt_d;
  logic [7:0] wpre_q, wpre_d;
  logic [RDW-1:0] rdiv_q, rdiv_d;
  logic [1:0] en_prev_q, trig_q, trig_d;
  logic take, wr_fire, pair, run_a, run_b, start_a, start_b, ld_a_wr, ld_b_wr;
  logic w_timeout, rtc_hit, wtick;
  logic [15:0] ha_value, hb_value;
  logic ha_to, ha_mh, ha_ev, hb_to, hb_mh, hb_ev, ha_oe, hb_oe;
  dhtcp_top_t top;

  // ==========================================================
  // Pin synchronisers: capture A, capture B, RTC clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      rtc_prev_q <= 1'b0;
    end else begin
      sync1_q <= {rtc_clk_in, cap_b_i, cap_a_i};
      sync2_q <= sync1_q;
      rtc_prev_q <= sync2_q[2];
    end
  end
  assign rtc_edge = sync2_q[2] & ~rtc_prev_q;

  // ==========================================================
  // Decoded controls
  assign top = dhtcp_top_t'(cfg_q[`DHTCP_CFG_TOP_LSB +: 2]);
  assign pair = (top == DHTCP_PAIR);
  assign run_a = ctrl_q[`DHTCP_CTRL_EN_A] & ~(ctrl_q[`DHTCP_CTRL_FRZ_A] & dbg_halt);
  assign run_b = ctrl_q[`DHTCP_CTRL_EN_B] & ~(ctrl_q[`DHTCP_CTRL_FRZ_B] & dbg_halt);
  // Enabling restarts from the load value; mode is assumed stable while enabled
  assign start_a = ctrl_q[`DHTCP_CTRL_EN_A] & ~en_prev_q[0];
  assign start_b = ctrl_q[`DHTCP_CTRL_EN_B] & ~en_prev_q[1];
  assign take = hsel & htrans[1] & hready;
  assign wr_fire = aph_wr_q;
  assign ld_a_wr = wr_fire && aph_addr_q == `DHTCP_OFF_LOAD_A;
  assign ld_b_wr = wr_fire && aph_addr_q == `DHTCP_OFF_LOAD_B;

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `DHTCP_OFF_CFG: rd_mux = {24'h000000, cfg_q};
      `DHTCP_OFF_CTRL: rd_mux = {20'h00000, ctrl_q};
      `DHTCP_OFF_IMASK: rd_mux = {25'h0000000, imask_q};
      `DHTCP_OFF_RIS: rd_mux = {25'h0000000, ris_q};
      `DHTCP_OFF_MIS: rd_mux = {25'h0000000, ris_q & imask_q};
      `DHTCP_OFF_LOAD_A: rd_mux = load_a_q;
      `DHTCP_OFF_LOAD_B: rd_mux = {16'h0000, load_b_q};
      `DHTCP_OFF_MATCH_A: rd_mux = match_a_q;
      `DHTCP_OFF_MATCH_B: rd_mux = {16'h0000, match_b_q};
      `DHTCP_OFF_PRESC_A: rd_mux = {24'h000000, presc_a_q};
      `DHTCP_OFF_PRESC_B: rd_mux = {24'h000000, presc_b_q};
      `DHTCP_OFF_VALUE_A: rd_mux = pair ? {16'h0000, ha_value} : wcnt_q;
      `DHTCP_OFF_VALUE_B: rd_mux = pair ? {16'h0000, hb_value} : 32'h00000000;
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  always_comb begin
    aph_wr_d = take & hwrite;
    aph_addr_d = take ? haddr[7:0] : aph_addr_q;
    hrdata_d = (take && !hwrite) ? rd_mux(haddr[7:0]) : hrdata_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_wr_q <= 1'b0;
      aph_addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
    end else begin
      aph_wr_q <= aph_wr_d;
      aph_addr_q <= aph_addr_d;
      hrdata_q <= hrdata_d;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // ==========================================================
  // Register file
  always_comb begin
    cfg_d = cfg_q;
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    load_a_d = load_a_q;
    load_b_d = load_b_q;
    match_a_d = match_a_q;
    match_b_d = match_b_q;
    presc_a_d = presc_a_q;
    presc_b_d = presc_b_q;
    clr = 7'h00;
    if (wr_fire) begin
      case (aph_addr_q)
        `DHTCP_OFF_CFG: cfg_d = hwdata[7:0];
        `DHTCP_OFF_CTRL: ctrl_d = hwdata[11:0];
        `DHTCP_OFF_IMASK: imask_d = hwdata[6:0];
        `DHTCP_OFF_ICLR: clr = hwdata[6:0];
        `DHTCP_OFF_LOAD_A: load_a_d = hwdata;
        `DHTCP_OFF_LOAD_B: load_b_d = hwdata[15:0];
        `DHTCP_OFF_MATCH_A: match_a_d = hwdata;
        `DHTCP_OFF_MATCH_B: match_b_d = hwdata[15:0];
        `DHTCP_OFF_PRESC_A: presc_a_d = hwdata[7:0];
        `DHTCP_OFF_PRESC_B: presc_b_d = hwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= `DHTCP_CFG_RST;
      ctrl_q <= `DHTCP_CTRL_RST;
      imask_q <= `DHTCP_IRQ_RST;
      load_a_q <= 32'h00000000;
      load_b_q <= 16'h0000;
      match_a_q <= 32'h00000000;
      match_b_q <= 16'h0000;
      presc_a_q <= 8'h00;
      presc_b_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      load_a_q <= load_a_d;
      load_b_q <= load_b_d;
      match_a_q <= match_a_d;
      match_b_q <= match_b_d;
      presc_a_q <= presc_a_d;
      presc_b_q <= presc_b_d;
    end
  end

  // ==========================================================
  // Wide counter: 32-bit one-shot, periodic and RTC
  assign wtick = (wpre_q == presc_a_q);
  always_comb begin
    wcnt_d = wcnt_q;
    wpre_d = wpre_q;
    rdiv_d = rdiv_q;
    w_timeout = 1'b0;
    rtc_hit = 1'b0;
    if (!pair) begin
      if (start_a) begin
        wcnt_d = load_a_q;
        wpre_d = 8'h00;
        rdiv_d = '0;
      end else if (ld_a_wr && run_a) begin
        wcnt_d = hwdata;
      end else if (run_a && top == DHTCP_WIDE_RTC) begin
        if (rtc_edge) begin
          if (rdiv_q == RDW'(RTC_DIV - 1)) begin
            rdiv_d = '0;
            wcnt_d = wcnt_q + 32'h00000001;
            rtc_hit = (wcnt_q + 32'h00000001 == match_a_q);
          end else begin
            rdiv_d = rdiv_q + RDW'(1);
          end
        end
      end else if (run_a) begin
        wpre_d = wtick ? 8'h00 : wpre_q + 8'h01;
        if (wtick) begin
          if (wcnt_q == 32'h00000000) begin
            if (top == DHTCP_WIDE_PERIODIC) begin
              wcnt_d = load_a_q;
            end
          end else begin
            wcnt_d = wcnt_q - 32'h00000001;
            w_timeout = (wcnt_q == 32'h00000001);
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wcnt_q <= 32'h00000000;
      wpre_q <= 8'h00;
      rdiv_q <= '0;
      en_prev_q <= 2'b00;
    end else begin
      wcnt_q <= wcnt_d;
      wpre_q <= wpre_d;
      rdiv_q <= rdiv_d;
      en_prev_q <= ctrl_q[`DHTCP_CTRL_EN_B:`DHTCP_CTRL_EN_A];
    end
  end

  // ==========================================================
  // Halves, active only in pair mode
  dhtcp_half u_half_a (
    .hclk(hclk), .hresetn(hresetn), .run(pair & run_a), .start(pair & start_a),
    .load_wr(ld_a_wr), .load_val(hwdata[15:0]), .load_q(load_a_q[15:0]), .match(match_a_q[15:0]),
    .presc(presc_a_q), .mode(dhtcp_half_t'(cfg_q[`DHTCP_CFG_A_LSB +: 3])),
    .edge_sel(dhtcp_edge_t'(ctrl_q[`DHTCP_CTRL_EDGE_A_LSB +: 2])), .inv(ctrl_q[`DHTCP_CTRL_INV_A]),
    .cap_in(sync2_q[0]), .value(ha_value), .timeout(ha_to), .match_hit(ha_mh), .cap_event(ha_ev),
    .pwm_o(cap_a_o), .pwm_oe(ha_oe)
  );
  dhtcp_half u_half_b (
    .hclk(hclk), .hresetn(hresetn), .run(pair & run_b), .start(pair & start_b),
    .load_wr(ld_b_wr), .load_val(hwdata[15:0]), .load_q(load_b_q), .match(match_b_q),
    .presc(presc_b_q), .mode(dhtcp_half_t'(cfg_q[`DHTCP_CFG_B_LSB +: 3])),
    .edge_sel(dhtcp_edge_t'(ctrl_q[`DHTCP_CTRL_EDGE_B_LSB +: 2])), .inv(ctrl_q[`DHTCP_CTRL_INV_B]),
    .cap_in(sync2_q[1]), .value(hb_value), .timeout(hb_to), .match_hit(hb_mh), .cap_event(hb_ev),
    .pwm_o(cap_b_o), .pwm_oe(hb_oe)
  );

  // ==========================================================
  // Sticky status, masking and triggers
  always_comb begin
    ev = 7'h00;
    ev[`DHTCP_IRQ_A_TIMEOUT] = pair ? ha_to : w_timeout;
    ev[`DHTCP_IRQ_A_MATCH] = ha_mh;
    ev[`DHTCP_IRQ_A_EVENT] = ha_ev;
    ev[`DHTCP_IRQ_RTC] = rtc_hit;
    ev[`DHTCP_IRQ_B_TIMEOUT] = hb_to;
    ev[`DHTCP_IRQ_B_MATCH] = hb_mh;
    ev[`DHTCP_IRQ_B_EVENT] = hb_ev;
    ris_d = (ris_q & ~clr) | ev;
    trig_d[0] = ev[`DHTCP_IRQ_A_TIMEOUT] & ctrl_q[`DHTCP_CTRL_TRG_A];
    trig_d[1] = ev[`DHTCP_IRQ_B_TIMEOUT] & ctrl_q[`DHTCP_CTRL_TRG_B];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ris_q <= `DHTCP_IRQ_RST;
      trig_q <= 2'b00;
    end else begin
      ris_q <= ris_d;
      trig_q <= trig_d;
    end
  end
  assign irq = |(ris_q & imask_q);
  assign trig_a = trig_q[0];
  assign trig_b = trig_q[1];
  // Pins turn into outputs only when a half is really in PWM mode
  assign cap_a_oe = pair & ha_oe;
  assign cap_b_oe = pair & hb_oe;

  // ==========================================================
  // Checks
  sequence s_clr_and_set;
    wr_fire && aph_addr_q == `DHTCP_OFF_ICLR && (ev & hwdata[6:0]) != 7'h00;
  endsequence
  AST_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
    s_clr_and_set |=> (ris_q & $past(ev)) == $past(ev)) else $error("event lost under clear");
  AST_CLEAR_DROPS: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_fire && aph_addr_q == `DHTCP_OFF_ICLR && ev == 7'h00
    |=> (ris_q & $past(hwdata[6:0])) == 7'h00) else $error("cleared flag still set");
  AST_IRQ_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == ((ris_q & imask_q) != 7'h00)) else $error("irq not masked status");
  AST_TRIG_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_a |-> $past(ctrl_q[`DHTCP_CTRL_TRG_A]) && $past(ev[`DHTCP_IRQ_A_TIMEOUT])) else $error("trigger not gated");
  AST_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
    !pair && dbg_halt && ctrl_q[`DHTCP_CTRL_FRZ_A] && !start_a && !ld_a_wr
    |=> wcnt_q == $past(wcnt_q)) else $error("counter ran during frozen halt");
  AST_RTC_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    top == DHTCP_WIDE_RTC && run_a && !start_a && !ld_a_wr && rtc_edge && rdiv_q == RDW'(RTC_DIV - 1)
    |=> wcnt_q == $past(wcnt_q) + 32'h00000001) else $error("rtc second missed");
  AST_WIDE_TIMEOUT: assert property (@(posedge hclk) disable iff (!hresetn)
    w_timeout && !pair |=> ris_q[`DHTCP_IRQ_A_TIMEOUT] ##1 wcnt_q == 32'h00000000 || top == DHTCP_WIDE_PERIODIC)
    else $error("wide timeout wrong");
  AST_NO_OUTPUT_UNLESS_PWM: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_a_oe |-> pair && cfg_q[`DHTCP_CFG_A_LSB +: 3] == 3'h4) else $error("pin driven outside pwm");
endmodule // dual_half_timer_capture_pwm

/* src/dhtcp_consts.svh */
// Register offsets, field positions, reset values and timing counts of the dual half timer
`ifndef DHTCP_CONSTS_SVH
`define DHTCP_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define DHTCP_OFF_CFG 8'h00
`define DHTCP_OFF_CTRL 8'h04
`define DHTCP_OFF_IMASK 8'h08
`define DHTCP_OFF_RIS 8'h0c
`define DHTCP_OFF_MIS 8'h10
`define DHTCP_OFF_ICLR 8'h14
`define DHTCP_OFF_LOAD_A 8'h18
`define DHTCP_OFF_LOAD_B 8'h1c
`define DHTCP_OFF_MATCH_A 8'h20
`define DHTCP_OFF_MATCH_B 8'h24
`define DHTCP_OFF_PRESC_A 8'h28
`define DHTCP_OFF_PRESC_B 8'h2c
`define DHTCP_OFF_VALUE_A 8'h30
`define DHTCP_OFF_VALUE_B 8'h34
// ==========================================================
// Field positions
`define DHTCP_CFG_TOP_LSB 0
`define DHTCP_CFG_A_LSB 2
`define DHTCP_CFG_B_LSB 5
`define DHTCP_CTRL_EN_A 0
`define DHTCP_CTRL_EN_B 1
`define DHTCP_CTRL_INV_A 2
`define DHTCP_CTRL_INV_B 3
`define DHTCP_CTRL_FRZ_A 4
`define DHTCP_CTRL_FRZ_B 5
`define DHTCP_CTRL_TRG_A 6
`define DHTCP_CTRL_TRG_B 7
`define DHTCP_CTRL_EDGE_A_LSB 8
`define DHTCP_CTRL_EDGE_B_LSB 10
`define DHTCP_IRQ_A_TIMEOUT 0
`define DHTCP_IRQ_A_MATCH 1
`define DHTCP_IRQ_A_EVENT 2
`define DHTCP_IRQ_RTC 3
`define DHTCP_IRQ_B_TIMEOUT 4
`define DHTCP_IRQ_B_MATCH 5
`define DHTCP_IRQ_B_EVENT 6
// ==========================================================
// Reset values
`define DHTCP_CFG_RST 8'h00
`define DHTCP_CTRL_RST 12'h000
`define DHTCP_IRQ_RST 7'h00
// ==========================================================
// Timing: RTC input rate in Hz, tick length in seconds
`define DHTCP_RTC_CLK_HZ 32768
`define DHTCP_RTC_TICK_S 1
`endif

/* src/dhtcp_pkg.sv */
// Types shared by the dual half timer files
package dhtcp_pkg;
  typedef enum logic [1:0] {
    DHTCP_WIDE_ONE_SHOT, DHTCP_WIDE_PERIODIC, DHTCP_WIDE_RTC, DHTCP_PAIR
  } dhtcp_top_t;
  typedef enum logic [2:0] {
    DHTCP_HALF_ONE_SHOT, DHTCP_HALF_PERIODIC, DHTCP_HALF_EDGE_COUNT, DHTCP_HALF_EDGE_TIME, DHTCP_HALF_PWM
  } dhtcp_half_t;
  typedef enum logic [1:0] {
    DHTCP_EDGE_RISE, DHTCP_EDGE_FALL, DHTCP_EDGE_BOTH
  } dhtcp_edge_t;
endpackage

/* src/dhtcp_half.sv */
// One 16-bit half: one-shot, periodic, edge count, edge time and PWM
`timescale 1ns/1ps
`include "dhtcp_consts.svh"
module dhtcp_half
  import dhtcp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic start,
  input wire logic load_wr,
  input wire logic [15:0] load_val,
  input wire logic [15:0] load_q,
  input wire logic [15:0] match,
  input wire logic [7:0] presc,
  input wire dhtcp_half_t mode,
  input wire dhtcp_edge_t edge_sel,
  input wire logic inv,
  input wire logic cap_in,
  output logic [15:0] value,
  output logic timeout,
  output logic match_hit,
  output logic cap_event,
  output logic pwm_o,
  output logic pwm_oe
);
  logic [15:0] cnt_q, cnt_d, cap_q, cap_d;
  logic [7:0] pre_q, pre_d;
  logic prev_q, pwm_q, pwm_d;
  logic rise, fall, edge_hit, tick;

  assign rise = cap_in & ~prev_q;
  assign fall = ~cap_in & prev_q;
  assign tick = (pre_q == presc);

  always_comb begin
    case (edge_sel)
      DHTCP_EDGE_RISE: edge_hit = rise;
      DHTCP_EDGE_FALL: edge_hit = fall;
      DHTCP_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Counter
  always_comb begin
    cnt_d = cnt_q;
    pre_d = pre_q;
    cap_d = cap_q;
    timeout = 1'b0;
    match_hit = 1'b0;
    cap_event = 1'b0;
    if (start) begin
      cnt_d = load_q;
      pre_d = 8'h00;
    end else if (load_wr && run) begin
      cnt_d = load_val;
      pre_d = 8'h00;
    end else if (run) begin
      case (mode)
        DHTCP_HALF_ONE_SHOT, DHTCP_HALF_PERIODIC, DHTCP_HALF_PWM: begin
          pre_d = tick ? 8'h00 : pre_q + 8'h01;
          if (tick) begin
            if (cnt_q == 16'h0000) begin
              if (mode != DHTCP_HALF_ONE_SHOT) begin
                cnt_d = load_q;
              end
            end else begin
              cnt_d = cnt_q - 16'h0001;
              timeout = (cnt_q == 16'h0001);
            end
          end
        end
        DHTCP_HALF_EDGE_COUNT: begin
          if (edge_hit) begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q - 16'h0001 == match) begin
              match_hit = 1'b1;
              cnt_d = load_q;
            end
          end
        end
        DHTCP_HALF_EDGE_TIME: begin
          pre_d = tick ? 8'h00 : pre_q + 8'h01;
          if (tick) begin
            cnt_d = cnt_q - 16'h0001;
          end
          if (edge_hit) begin
            cap_d = cnt_q;
            cap_event = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Edge-aligned: active while the count lies above the match value
  always_comb begin
    pwm_d = inv;
    if (mode == DHTCP_HALF_PWM && run) begin
      pwm_d = (cnt_q > match) ^ inv;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0000;
      pre_q <= 8'h00;
      cap_q <= 16'h0000;
      prev_q <= 1'b0;
      pwm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      cap_q <= cap_d;
      prev_q <= cap_in;
      pwm_q <= pwm_d;
    end
  end

  assign value = (mode == DHTCP_HALF_EDGE_TIME) ? cap_q : cnt_q;
  assign pwm_o = pwm_q;
  assign pwm_oe = (mode == DHTCP_HALF_PWM);

  // ==========================================================
  // Checks
  sequence s_os_zero;
    run && !start && !load_wr && mode == DHTCP_HALF_ONE_SHOT && cnt_q == 16'h0000;
  endsequence
  AST_ONE_SHOT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    s_os_zero |=> cnt_q == 16'h0000) else $error("one-shot left zero");
  AST_PERIODIC_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    run && !start && !load_wr && tick && mode == DHTCP_HALF_PERIODIC && cnt_q == 16'h0000
    |=> cnt_q == $past(load_q)) else $error("periodic missed reload");
  AST_LOAD_NOW: assert property (@(posedge hclk) disable iff (!hresetn)
    run && load_wr && !start |=> cnt_q == $past(load_val)) else $error("load not immediate");
  AST_PWM_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == DHTCP_HALF_PWM && run ##1 mode == DHTCP_HALF_PWM
    |-> pwm_o == (($past(cnt_q) > $past(match)) ^ $past(inv))) else $error("pwm level wrong");
endmodule // dhtcp_half

/* src/placeholder_removed.sv */
// Intentionally empty
`timescale 1ns/1ps

/* testbench/dhtcp_pin_model.sv */
// Far-side model of one capture/PWM pin
`timescale 1ns/1ps
module dhtcp_pin_model (
  input wire logic hclk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_i
);
  logic drv = 1'b0;
  // The device owns the line while its output enable is high
  assign pin_i = pin_oe ? pin_o : drv;
  task automatic pulse();
    drv <= 1'b1;
    repeat (5) @(posedge hclk);
    drv <= 1'b0;
    repeat (5) @(posedge hclk);
  endtask
endmodule // dhtcp_pin_model

/* testbench/dual_half_timer_capture_pwm_test.sv */
// Self-checking bench of the dual half timer
`timescale 1ns/1ps
`include "dhtcp_consts.svh"
module dual_half_timer_capture_pwm_test
  import dhtcp_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic dbg_halt = 1'b0;
  logic rtc_clk = 1'b0;
  logic hreadyout, hresp, cap_a_o, cap_a_oe, cap_b_o, cap_b_oe, trig_a, trig_b, irq, line_a, line_b;
  logic [31:0] hrdata, r, s, x = 32'he25f;
  int mismatches = 0, checks = 0, cyc = 0, trig_n = 0, n, ld, p;
  always #12.5 hclk = ~hclk;
  dual_half_timer_capture_pwm #(.RTC_DIV(4)) dual_half_timer_capture_pwm_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(1'b1),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dbg_halt(dbg_halt), .rtc_clk_in(rtc_clk),
    .cap_a_i(line_a), .cap_a_o(cap_a_o), .cap_a_oe(cap_a_oe), .cap_b_i(line_b), .cap_b_o(cap_b_o),
    .cap_b_oe(cap_b_oe), .trig_a(trig_a), .trig_b(trig_b), .irq(irq));
  dhtcp_pin_model pin_a_model (.hclk(hclk), .pin_o(cap_a_o), .pin_oe(cap_a_oe), .pin_i(line_a));
  dhtcp_pin_model pin_b_model (.hclk(hclk), .pin_o(cap_b_o), .pin_oe(cap_b_oe), .pin_i(line_b));
  // ==========================================================
  // Helpers
  always @(posedge hclk) begin
    cyc++;
    if (trig_a === 1'b1) trig_n++;
    if (cyc == 40000) begin
      mismatches++;
      final_report();
    end
  end
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // Edge count value after two pulses, reload on reaching the match value
  function automatic logic [31:0] exp_cnt(input int e);
    int v;
    v = 20;
    for (int k = 0; k < ((e == 2) ? 4 : (e == 3) ? 0 : 2); k++) begin
      v--;
      if (v == 17) v = 20;
    end
    return v;
  endfunction
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, r);
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    ahb(1'b0, a, 32'h0, s);
    cmp(nm, e, s);
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin n++; @(posedge hclk); end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(`DHTCP_OFF_CFG, 0, "cfg");
    chk(`DHTCP_OFF_CTRL, 0, "ctrl");
    chk(`DHTCP_OFF_IMASK, 0, "imask");
    chk(`DHTCP_OFF_RIS, 0, "ris");
    chk(8'h40, 0, "unmapped");
    for (int i = 0; i < 2; i++) begin
      ld = rnd() % 30 + 2;
      p = rnd() % 3;
      wr(`DHTCP_OFF_CFG, 32'ha3);
      wr(`DHTCP_OFF_LOAD_A, ld);
      wr(`DHTCP_OFF_PRESC_A, p);
      wr(`DHTCP_OFF_IMASK, 32'h1);
      trig_n = 0;
      wr(`DHTCP_OFF_CTRL, 32'h41);
      wait_irq();
      cmp("ticks", 1, n >= ld * (p + 1) && n <= ld * (p + 1) + 2);
      repeat (5) @(posedge hclk);
      chk(`DHTCP_OFF_VALUE_A, 0, "one_shot value");
      chk(`DHTCP_OFF_MIS, 1, "mis");
      cmp("trig", 1, trig_n);
      wr(`DHTCP_OFF_ICLR, 32'h1);
      chk(`DHTCP_OFF_RIS, 0, "ris clr");
      cmp("irq", 0, irq);
      wr(`DHTCP_OFF_CTRL, 0);
      $display("test one_shot %0d done", i);
    end
    wr(`DHTCP_OFF_CFG, 32'h1);
    wr(`DHTCP_OFF_LOAD_A, 40);
    wr(`DHTCP_OFF_PRESC_A, 0);
    wr(`DHTCP_OFF_CTRL, 32'h11);
    wait_irq();
    repeat (5) @(posedge hclk);
    ahb(1'b0, `DHTCP_OFF_VALUE_A, 0, s);
    cmp("periodic reload", 1, s > 20 && s <= 40);
    wr(`DHTCP_OFF_LOAD_A, 32'h10000);
    ahb(1'b0, `DHTCP_OFF_VALUE_A, 0, s);
    cmp("wide load", 1, s > 32'hffe0 && s <= 32'h10000);
    dbg_halt <= 1'b1;
    ahb(1'b0, `DHTCP_OFF_VALUE_A, 0, s);
    chk(`DHTCP_OFF_VALUE_A, s, "frozen");
    dbg_halt <= 1'b0;
    ahb(1'b0, `DHTCP_OFF_VALUE_A, 0, s);
    chk(`DHTCP_OFF_VALUE_A, s - 3, "running");
    wr(`DHTCP_OFF_CTRL, 0);
    $display("test periodic done");
    wr(`DHTCP_OFF_CFG, 32'h0);
    wr(`DHTCP_OFF_LOAD_A, 32'hc);
    wr(`DHTCP_OFF_ICLR, 32'h7f);
    wr(`DHTCP_OFF_CTRL, 32'h1);
    wait_irq();
    cmp("wide ticks", 1, n >= 12 && n <= 14);
    repeat (5) @(posedge hclk);
    chk(`DHTCP_OFF_VALUE_A, 0, "wide one_shot value");
    wr(`DHTCP_OFF_CTRL, 0);
    wr(`DHTCP_OFF_CFG, 32'h2);
    wr(`DHTCP_OFF_LOAD_A, 0);
    wr(`DHTCP_OFF_MATCH_A, 2);
    wr(`DHTCP_OFF_ICLR, 32'h7f);
    wr(`DHTCP_OFF_CTRL, 32'h1);
    repeat (16) begin repeat (4) @(posedge hclk); rtc_clk <= ~rtc_clk; end
    repeat (5) @(posedge hclk);
    chk(`DHTCP_OFF_VALUE_A, 2, "rtc seconds");
    ahb(1'b0, `DHTCP_OFF_RIS, 0, s);
    cmp("rtc match", 1, s[3]);
    wr(`DHTCP_OFF_CTRL, 0);
    $display("test wide one_shot and rtc done");
    for (int e = 0; e < 4; e++) begin
      wr(`DHTCP_OFF_CFG, 32'h57);
      wr(`DHTCP_OFF_LOAD_B, 20);
      wr(`DHTCP_OFF_MATCH_B, 17);
      wr(`DHTCP_OFF_ICLR, 32'h7f);
      wr(`DHTCP_OFF_CTRL, 32'h2 | (e << 10));
      pin_b_model.pulse();
      pin_b_model.pulse();
      chk(`DHTCP_OFF_VALUE_B, exp_cnt(e), "edge count");
      ahb(1'b0, `DHTCP_OFF_RIS, 0, s);
      cmp("count match", e == 2, s[5]);
      wr(`DHTCP_OFF_CTRL, 0);
    end
    wr(`DHTCP_OFF_CFG, 32'haf);
    wr(`DHTCP_OFF_ICLR, 32'h7f);
    wr(`DHTCP_OFF_CTRL, 32'h1);
    pin_a_model.pulse();
    ahb(1'b0, `DHTCP_OFF_RIS, 0, s);
    cmp("time event", 1, s[2]);
    wr(`DHTCP_OFF_CTRL, 0);
    $display("test capture done");
    for (int inv = 0; inv < 2; inv++) begin
      wr(`DHTCP_OFF_CFG, 32'hb3);
      wr(`DHTCP_OFF_LOAD_A, 9);
      wr(`DHTCP_OFF_MATCH_A, 6);
      wr(`DHTCP_OFF_CTRL, 32'h1 | (inv << 2));
      cmp("pwm oe", 1, cap_a_oe);
      cmp("pin b oe", 0, cap_b_oe);
      repeat (30) @(posedge hclk);
      n = 0;
      repeat (20) begin @(posedge hclk); n += (line_a === 1'b1); end
      cmp("pwm highs", inv ? 14 : 6, n);
      wr(`DHTCP_OFF_CTRL, 0);
    end
    $display("test pwm done");
    final_report();
  end
endmodule // dual_half_timer_capture_pwm_test
